// >>> src/smh_map.vh
`ifndef SMH_MAP_VH
`define SMH_MAP_VH
// Register word addresses.
`define SMH_REG_COMM_EN      8'h00
`define SMH_REG_ACCEL        8'h03
`define SMH_REG_POS_GAIN     8'h07
`define SMH_REG_DIR_POL      8'h09
`define SMH_REG_GEAR_NUM     8'h0a
`define SMH_REG_GEAR_DEN     8'h0b
`define SMH_REG_TARGET_LO    8'h0c
`define SMH_REG_ABS_POS      8'h16
`define SMH_REG_SPECIAL      8'h19
`define SMH_REG_STATUS       8'h20
`define SMH_REG_PARAM_SAVE   8'h21
// Bus function codes.
`define SMH_FN_READ          8'h03
`define SMH_FN_WRITE         8'h06
// Special-function values.
`define SMH_SF_MECH_HOME     16'h0001
`define SMH_SF_FOLLOW        16'h0002
`define SMH_SF_SWITCH_HOME   16'h0008
`define SMH_SF_TURN_MIN      16'h000a
`define SMH_SF_TURN_MAX      16'h8000
// Acceleration threshold for raw pulse following.
`define SMH_ACCEL_RAW        16'hea60
// Mechanical back-off, 36 degrees of a 32768 count turn.
`define SMH_BACKOFF_COUNTS   16'h0ccd
// Reset values.
`define SMH_RST_GEAR_NUM     16'h0001
`define SMH_RST_GEAR_DEN     16'h0001
`define SMH_RST_ACCEL        16'h03e8
`define SMH_RST_POS_GAIN     16'h03e8
// Stall detection time in microseconds, and its cycle count at 20 MHz.
`define SMH_STALL_US         1000
`define SMH_CLK_MHZ          20
`define SMH_STALL_CYCLES     (`SMH_STALL_US * `SMH_CLK_MHZ)
// Status field positions.
`define SMH_ST_HOMING        0
`define SMH_ST_HOMED         1
`define SMH_ST_FOLLOW        2
`define SMH_ST_ESTOP         3
`endif

// >>> src/smh_servo_motion_homing_control.v
`timescale 1ns/10ps
`default_nettype none
`include "smh_map.vh"

module smh_servo_motion_homing_control #(
    parameter STALL_CYCLES = `SMH_STALL_CYCLES
) (
    input  wire        clock,
    input  wire        rst,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_func,
    input  wire [7:0]  cmd_addr,
    input  wire [15:0] cmd_wdata,
    output reg         rsp_valid,
    output reg  [15:0] rsp_rdata,
    output reg         rsp_error,
    input  wire        pulse_phase_input,
    input  wire        dir_phase_input,
    input  wire        enable_switch,
    input  wire        index_pulse,
    input  wire        motor_stalled,
    input  wire [14:0] turn_position,
    input  wire [15:0] saved_gear_num,
    input  wire [15:0] saved_special,
    output reg         step_pulse,
    output reg         step_forward,
    output reg  [15:0] step_rate,
    output reg         save_request,
    output reg  [15:0] abs_position_r
);

    localparam ST_IDLE    = 3'd0;
    localparam ST_BOOT    = 3'd1;
    localparam ST_SEARCH  = 3'd2;
    localparam ST_BACKOFF = 3'd3;
    localparam ST_INDEX   = 3'd4;
    localparam ST_TURN    = 3'd5;

    reg        comm_en_r;
    reg [15:0] accel_r;
    reg [15:0] pos_gain_r;
    reg        dir_pol_r;
    reg [15:0] gear_num_r;
    reg [15:0] gear_den_r;
    reg [15:0] target_r;
    reg [15:0] special_r;
    reg [2:0]  state_r;
    reg [15:0] home_cnt_r;
    reg [15:0] stall_cnt_r;
    reg [15:0] decel_r;
    reg        estop_r;
    reg [31:0] gear_acc_r;
    reg [15:0] ramp_r;
    reg        boot_r;
    reg [1:0]  pa_sync_r;
    reg [1:0]  pb_sync_r;
    reg [1:0]  en_sync_r;
    reg [1:0]  ix_sync_r;
    reg [1:0]  st_sync_r;
    reg        pa_d_r;
    reg        ix_d_r;

    wire pa = pa_sync_r[1];
    wire pb = pb_sync_r[1];
    wire en_sw = en_sync_r[1];
    wire index_rise = ix_sync_r[1] & ~ix_d_r;
    wire pa_rise = pa & ~pa_d_r;
    wire is_write = cmd_valid & (cmd_func == `SMH_FN_WRITE);
    wire is_read = cmd_valid & (cmd_func == `SMH_FN_READ);
    wire follow_mode = (special_r == `SMH_SF_FOLLOW) & (gear_num_r != 16'h0000);
    wire homing = (state_r != ST_IDLE);
    wire raw_follow = (accel_r >= `SMH_ACCEL_RAW);
    wire special_mode = (gear_num_r == 16'h0000) & comm_en_r;

    // Searching runs in the polarity-chosen reverse sense.
    function search_dir;
        input pol;
        begin
            search_dir = pol;
        end
    endfunction

    // Single-turn target check used only at boot.
    function is_turn_value;
        input [15:0] v;
        begin
            is_turn_value = (v >= `SMH_SF_TURN_MIN) && (v <= `SMH_SF_TURN_MAX);
        end
    endfunction

    // Read multiplexer; unknown addresses answer zero with error.
    function [16:0] read_mux;
        input [7:0] a;
        begin
            case (a)
                `SMH_REG_COMM_EN:   read_mux = {1'b0, 15'h0000, comm_en_r};
                `SMH_REG_ACCEL:     read_mux = {1'b0, accel_r};
                `SMH_REG_POS_GAIN:  read_mux = {1'b0, pos_gain_r};
                `SMH_REG_DIR_POL:   read_mux = {1'b0, 15'h0000, dir_pol_r};
                `SMH_REG_GEAR_NUM:  read_mux = {1'b0, gear_num_r};
                `SMH_REG_GEAR_DEN:  read_mux = {1'b0, gear_den_r};
                `SMH_REG_TARGET_LO: read_mux = {1'b0, target_r};
                `SMH_REG_ABS_POS:   read_mux = {1'b0, abs_position_r};
                `SMH_REG_SPECIAL:   read_mux = {1'b0, special_r};
                `SMH_REG_STATUS:    read_mux = {1'b0, 12'h000, estop_r,
                                        follow_mode, boot_r, homing};
                default:            read_mux = {1'b1, 16'h0000};
            endcase
        end
    endfunction

    // Read word with its error flag; a function result cannot be sliced.
    wire [16:0] rd_mux = read_mux(cmd_addr);

    // Pin inputs pass two flops before any logic sees them.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pa_sync_r <= 2'b00;
            pb_sync_r <= 2'b00;
            en_sync_r <= 2'b00;
            ix_sync_r <= 2'b00;
            st_sync_r <= 2'b00;
            pa_d_r    <= 1'b0;
            ix_d_r    <= 1'b0;
        end else begin
            pa_sync_r <= {pa_sync_r[0], pulse_phase_input};
            pb_sync_r <= {pb_sync_r[0], dir_phase_input};
            en_sync_r <= {en_sync_r[0], enable_switch};
            ix_sync_r <= {ix_sync_r[0], index_pulse};
            st_sync_r <= {st_sync_r[0], motor_stalled};
            pa_d_r    <= pa;
            ix_d_r    <= ix_sync_r[1];
        end
    end

    // Register bus, boot loading and homing share one process so every
    // control register has a single driver.
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            comm_en_r      <= 1'b0;
            accel_r        <= `SMH_RST_ACCEL;
            pos_gain_r     <= `SMH_RST_POS_GAIN;
            dir_pol_r      <= 1'b0;
            gear_num_r     <= `SMH_RST_GEAR_NUM;
            gear_den_r     <= `SMH_RST_GEAR_DEN;
            target_r       <= 16'h0000;
            special_r      <= 16'h0000;
            abs_position_r <= 16'h0000;
            state_r        <= ST_BOOT;
            home_cnt_r     <= 16'h0000;
            stall_cnt_r    <= 16'h0000;
            decel_r        <= 16'h0000;
            estop_r        <= 1'b0;
            gear_acc_r     <= 32'h0000_0000;
            ramp_r         <= 16'h0000;
            boot_r         <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_rdata      <= 16'h0000;
            rsp_error      <= 1'b0;
            step_pulse     <= 1'b0;
            step_forward   <= 1'b0;
            step_rate      <= 16'h0000;
            save_request   <= 1'b0;
        end else begin
            rsp_valid    <= cmd_valid;
            rsp_error    <= 1'b0;
            rsp_rdata    <= 16'h0000;
            step_pulse   <= 1'b0;
            save_request <= 1'b0;
            if (is_read) begin
                rsp_rdata <= rd_mux[15:0];
                rsp_error <= rd_mux[16];
            end else if (cmd_valid && !is_write) begin
                rsp_error <= 1'b1;
            end
            // Deceleration tail: one step per cycle until spent. It sits
            // ahead of the bus writes so that a new stop wins over the end.
            if (estop_r) begin
                if (decel_r != 16'h0000) begin
                    decel_r    <= decel_r - 16'h0001;
                    step_pulse <= 1'b1;
                end else begin
                    estop_r <= 1'b0;
                end
            end

            if (is_write) begin
                case (cmd_addr)
                    `SMH_REG_COMM_EN:    comm_en_r <= cmd_wdata[0];
                    `SMH_REG_ACCEL:      accel_r <= cmd_wdata;
                    `SMH_REG_POS_GAIN:   pos_gain_r <= cmd_wdata;
                    `SMH_REG_DIR_POL:    dir_pol_r <= cmd_wdata[0];
                    `SMH_REG_GEAR_NUM:   gear_num_r <= cmd_wdata;
                    `SMH_REG_GEAR_DEN:   gear_den_r <= cmd_wdata;
                    `SMH_REG_PARAM_SAVE: save_request <= cmd_wdata[0];
                    `SMH_REG_TARGET_LO: begin
                        target_r <= cmd_wdata;
                        // Emergency stop keeps a gain-sized decel tail.
                        if (special_mode && cmd_wdata == 16'h0000) begin
                            estop_r <= 1'b1;
                            decel_r <= pos_gain_r;
                        end
                    end
                    `SMH_REG_ABS_POS: begin
                        if (special_mode && cmd_wdata == 16'h0000)
                            abs_position_r <= 16'h0000;
                        else if (!special_mode)
                            abs_position_r <= cmd_wdata;
                    end
                    `SMH_REG_SPECIAL: begin
                        special_r <= cmd_wdata;
                        if (cmd_wdata == `SMH_SF_MECH_HOME) begin
                            state_r     <= ST_SEARCH;
                            stall_cnt_r <= 16'h0000;
                        end
                    end
                    default: rsp_error <= 1'b1;
                endcase
            end

            // Homing state machine.
            case (state_r)
                ST_BOOT: begin
                    boot_r     <= 1'b1;
                    special_r  <= saved_special;
                    gear_num_r <= saved_gear_num;
                    if (saved_gear_num == 16'h0000)
                        comm_en_r <= 1'b1;
                    if (saved_special == `SMH_SF_MECH_HOME ||
                        saved_special == `SMH_SF_SWITCH_HOME) begin
                        state_r <= ST_SEARCH;
                    end else if (is_turn_value(saved_special)) begin
                        state_r <= ST_TURN;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_SEARCH: begin
                    // Step toward the origin in the polarity sense.
                    step_forward <= search_dir(dir_pol_r);
                    step_pulse   <= 1'b1;
                    if (special_r == `SMH_SF_SWITCH_HOME) begin
                        if (en_sw)
                            state_r <= ST_INDEX;
                    end else if (st_sync_r[1]) begin
                        if (stall_cnt_r >= STALL_CYCLES[15:0]) begin
                            state_r    <= ST_BACKOFF;
                            home_cnt_r <= `SMH_BACKOFF_COUNTS;
                        end else begin
                            stall_cnt_r <= stall_cnt_r + 16'h0001;
                        end
                    end else begin
                        stall_cnt_r <= 16'h0000;
                    end
                end
                ST_BACKOFF: begin
                    step_forward <= ~search_dir(dir_pol_r);
                    if (home_cnt_r != 16'h0000) begin
                        step_pulse <= 1'b1;
                        home_cnt_r <= home_cnt_r - 16'h0001;
                    end else begin
                        abs_position_r <= 16'h0000;
                        state_r        <= ST_IDLE;
                    end
                end
                ST_INDEX: begin
                    step_forward <= ~search_dir(dir_pol_r);
                    step_pulse   <= ~index_rise;
                    if (index_rise) begin
                        abs_position_r <= 16'h0000;
                        state_r        <= ST_IDLE;
                    end
                end
                ST_TURN: begin
                    // Absolute single-turn reading: no search needed.
                    if ({1'b0, turn_position} ==
                        (special_r & 16'h7fff)) begin
                        abs_position_r <= 16'h0000;
                        state_r        <= ST_IDLE;
                    end else if (!step_pulse) begin
                        // One step in flight, so the reading never lags.
                        step_forward <= search_dir(dir_pol_r);
                        step_pulse   <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    // Pulses count only when no homing is active.
                    if (follow_mode && pa_rise && !estop_r) begin
                        gear_acc_r <= gear_acc_r + {16'h0000, gear_num_r};
                        step_forward <= ~pb ^ dir_pol_r;
                    end else if (gear_acc_r >= {16'h0000, gear_den_r}) begin
                        gear_acc_r <= gear_acc_r
                                      - {16'h0000, gear_den_r};
                        step_pulse <= 1'b1;
                        abs_position_r <= step_forward
                                        ? abs_position_r + 16'h0001
                                        : abs_position_r - 16'h0001;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase

            // Rate output: ramp or raw pulse rate.
            if (raw_follow) begin
                step_rate <= 16'hffff;
                ramp_r    <= 16'h0000;
            end else begin
                ramp_r    <= (ramp_r < accel_r) ? ramp_r + 16'h0001
                                                : accel_r;
                step_rate <= ramp_r;
            end
        end
    end

endmodule // smh_servo_motion_homing_control
`default_nettype wire

// >>> testbench/smh_quad_host.sv
`timescale 1ns/10ps
`default_nettype none
// Quadrature source standing in for the followed encoder.
module smh_quad_host (
    input  wire  clock,
    output logic pa,
    output logic pb
);
    // The lines rest low between bursts, as a parked encoder would.
    initial begin
        pa = 1'b0;
        pb = 1'b0;
    end
    // Four clocks per state so the two-flop sync sees every edge.
    task automatic run(input logic fwd, input int n);
        int i;
        int k;
        for (i = 0; i < n; i++) begin
            for (k = 0; k < 4; k++) begin
                repeat (4) @(posedge clock);
                #5;
                pa = fwd ? (k < 2) : (k == 1 || k == 2);
                pb = fwd ? (k == 1 || k == 2) : (k < 2);
            end
        end
    endtask
endmodule // smh_quad_host
`default_nettype wire

// >>> testbench/smh_checker_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "smh_map.vh"
// Register port timing and the gated position clear.
module smh_checker (
    input wire        clock,
    input wire        rst,
    input wire        cmd_valid,
    input wire [7:0]  cmd_func,
    input wire [7:0]  cmd_addr,
    input wire [15:0] cmd_wdata,
    input wire        rsp_valid,
    input wire [15:0] rsp_rdata,
    input wire        rsp_error,
    input wire        save_request,
    input wire [15:0] abs_position_r
);
    wire wr = cmd_valid && cmd_func == `SMH_FN_WRITE;
    reg  gz_r;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // A zero gear loaded at boot is not seen, so the clear check may skip it.
    always @(posedge clock or posedge rst) begin
        if (rst)
            gz_r <= 1'b0;
        else if (wr && cmd_addr == `SMH_REG_GEAR_NUM)
            gz_r <= cmd_wdata == 16'h0000;
    end
    property p_rsp; cmd_valid |=> rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("missing answer");
    property p_idle; !cmd_valid |=> !rsp_valid && !rsp_error; endproperty
    a_idle: assert property (p_idle) else $error("stray answer");
    property p_func;
        cmd_valid && cmd_func != `SMH_FN_READ && !wr |=> rsp_error;
    endproperty
    a_func: assert property (p_func) else $error("bad code taken");
    property p_addr; cmd_valid && cmd_addr[7] |=> rsp_error; endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_gear;
        cmd_valid && cmd_func == `SMH_FN_READ &&
        cmd_addr == `SMH_REG_GEAR_NUM |=> !rsp_error;
    endproperty
    a_gear: assert property (p_gear) else $error("gear read refused");
    property p_wdata; wr && !cmd_addr[7] |=> rsp_rdata == 16'h0000; endproperty
    a_wdata: assert property (p_wdata) else $error("write data back");
    sequence s_save;
        wr && cmd_addr == `SMH_REG_PARAM_SAVE && cmd_wdata == 16'h0001;
    endsequence
    property p_save; s_save |=> save_request; endproperty
    a_save: assert property (p_save) else $error("no save pulse");
    property p_save_src;
        save_request |-> $past(wr && cmd_addr == `SMH_REG_PARAM_SAVE);
    endproperty
    a_save_src: assert property (p_save_src) else $error("stray save");
    property p_clear;
        gz_r && wr && cmd_addr == `SMH_REG_ABS_POS && cmd_wdata == 16'h0000
        |=> ##[0:2] abs_position_r == 16'h0000;
    endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    c_err: cover property (cmd_valid && cmd_addr[7] ##1 rsp_error);
    c_save: cover property (save_request);
    c_clear: cover property (gz_r && wr && cmd_addr == `SMH_REG_ABS_POS);
endmodule // smh_checker
bind smh_servo_motion_homing_control smh_checker u_chk (
    .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
    .save_request(save_request), .abs_position_r(abs_position_r)
);
`default_nettype wire

// >>> testbench/servo_motion_homing_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "smh_map.vh"
// Self-checking bench for the motion and homing block.
module servo_motion_homing_control_tb;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    logic [7:0]  cmd_func = 8'h00;
    logic [7:0]  cmd_addr = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic [14:0] turn_position = 15'h0000;
    logic [15:0] saved_gear_num = 16'h0001;
    logic [15:0] saved_special = 16'h0000;
    logic        stall_pin = 1'b0;
    logic        sw_pin = 1'b0;
    logic        ix_pin = 1'b0;
    logic        rsp_valid, rsp_error, step_pulse, step_forward;
    logic        save_request, pa, pb, er;
    logic [15:0] rsp_rdata, step_rate, abs_position_r, rd;
    int          bad_count = 0;
    int          checks_done = 0;
    int          steps = 0;
    int          fsteps = 0;
    int          n1;

    // Clock of 50 ns period.
    always #25 clock = ~clock;

    smh_servo_motion_homing_control #(.STALL_CYCLES(4)) dut (
        .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_func(cmd_func), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error),
        .pulse_phase_input(pa), .dir_phase_input(pb),
        .enable_switch(sw_pin), .index_pulse(ix_pin),
        .motor_stalled(stall_pin),
        .turn_position(turn_position), .saved_gear_num(saved_gear_num),
        .saved_special(saved_special), .step_pulse(step_pulse),
        .step_forward(step_forward), .step_rate(step_rate),
        .save_request(save_request), .abs_position_r(abs_position_r)
    );
    smh_quad_host host (.clock(clock), .pa(pa), .pb(pb));

    // The shaft follows the steps; a wrong-way step moves it back.
    always @(posedge clock) begin
        if (step_pulse === 1'b1) begin
            steps <= steps + 1;
            fsteps <= fsteps + (step_forward === 1'b1);
            turn_position <= turn_position +
                (step_forward === 1'b1 ? 15'h0001 : 15'h7fff);
        end
    end

    task chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    // Request is held through the taking edge; the answer stands the
    // following cycle only, so it is read just after that edge.
    task cmd(input logic [7:0] f, input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        #5;
        cmd_valid = 1'b1;
        cmd_func = f;
        cmd_addr = a;
        cmd_wdata = d;
        @(posedge clock);
        #5;
        cmd_valid = 1'b0;
        rd = rsp_rdata;
        er = rsp_error;
        chk(rsp_valid === 1'b1, "no answer");
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        cmd(`SMH_FN_WRITE, a, d);
    endtask
    task rdc(input logic [7:0] a);
        cmd(`SMH_FN_READ, a, 16'h0000);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask
    task boot(input logic [15:0] g, input logic [15:0] s, input logic [14:0] t);
        rst = 1'b1;
        saved_gear_num = g;
        saved_special = s;
        turn_position = t;
        idle(5);
        rst = 1'b0;
    endtask

    task t_regs;
        rdc(`SMH_REG_ACCEL);
        chk(rd === `SMH_RST_ACCEL && er === 1'b0, "accel reset");
        wr(`SMH_REG_GEAR_NUM, 16'hbeef);
        rdc(`SMH_REG_GEAR_NUM);
        chk(rd === 16'hbeef, "gear readback");
        cmd(8'h10, `SMH_REG_GEAR_NUM, 16'h0000);
        chk(er === 1'b1, "bad code accepted");
        rdc(8'h80);
        chk(er === 1'b1, "unmapped accepted");
        wr(`SMH_REG_GEAR_NUM, 16'h0001);
        $display("test regs done");
    endtask

    task t_follow;
        wr(`SMH_REG_COMM_EN, 16'h0001);
        wr(`SMH_REG_SPECIAL, `SMH_SF_FOLLOW);
        wr(`SMH_REG_PARAM_SAVE, 16'h0001);
        wr(`SMH_REG_ACCEL, `SMH_ACCEL_RAW);
        rdc(`SMH_REG_STATUS);
        chk(rd[`SMH_ST_FOLLOW] === 1'b1, "follow flag");
        steps = 0;
        fsteps = 0;
        host.run(1'b1, 8);
        idle(300);
        n1 = steps;
        chk(n1 > 0 && fsteps == n1, "forward follow");
        chk(step_rate === 16'hffff, "raw rate");
        steps = 0;
        fsteps = 0;
        host.run(1'b0, 8);
        idle(300);
        chk(steps == n1 && fsteps == 0, "reverse follow");
        wr(`SMH_REG_GEAR_NUM, 16'h0002);
        steps = 0;
        host.run(1'b1, 8);
        idle(300);
        chk(steps == 2 * n1, "gear ratio");
        $display("test follow done");
    endtask

    task t_stop;
        wr(`SMH_REG_SPECIAL, 16'h0000);
        wr(`SMH_REG_POS_GAIN, 16'h0005);
        wr(`SMH_REG_GEAR_NUM, 16'h0000);
        steps = 0;
        wr(`SMH_REG_TARGET_LO, 16'h0000);
        rdc(`SMH_REG_STATUS);
        chk(rd[`SMH_ST_ESTOP] === 1'b1, "stop flag");
        idle(100);
        chk(steps == 5, "stop tail length");
        wr(`SMH_REG_ABS_POS, 16'h0000);
        chk(abs_position_r === 16'h0000, "clear");
        wr(`SMH_REG_ABS_POS, 16'h0123);
        chk(abs_position_r === 16'h0000, "nonzero write taken");
        $display("test stop done");
    endtask

    task t_mech;
        fsteps = 0;
        wr(`SMH_REG_SPECIAL, `SMH_SF_MECH_HOME);
        idle(10);
        chk(step_pulse === 1'b1 && step_forward === 1'b0,
            "mech search");
        stall_pin = 1'b1;
        idle(3400);
        stall_pin = 1'b0;
        chk(fsteps == `SMH_BACKOFF_COUNTS, "back-off length");
        rdc(`SMH_REG_STATUS);
        chk(rd[`SMH_ST_HOMING] === 1'b0, "mech homed");
        $display("test mech done");
    endtask

    task t_switch;
        boot(16'h0000, `SMH_SF_SWITCH_HOME, 15'h0000);
        idle(10);
        chk(step_pulse === 1'b1 && step_forward === 1'b0,
            "switch search");
        sw_pin = 1'b1;
        idle(10);
        chk(step_forward === 1'b1, "index turn");
        ix_pin = 1'b1;
        idle(5);
        ix_pin = 1'b0;
        sw_pin = 1'b0;
        rdc(`SMH_REG_STATUS);
        chk(rd[`SMH_ST_HOMING] === 1'b0, "switch homed");
        $display("test switch done");
    endtask

    task t_home;
        int i;
        boot(16'h0000, 16'h0064, 15'h0096);
        for (i = 0; i < 40000 && turn_position !== 15'h0064; i++)
            @(posedge clock);
        idle(100);
        chk(turn_position === 15'h0064, "turn target");
        chk(abs_position_r === 16'h0000, "origin zero");
        rdc(`SMH_REG_STATUS);
        chk(rd[`SMH_ST_HOMED] === 1'b1 && rd[`SMH_ST_HOMING] === 1'b0,
            "homed flag");
        rdc(`SMH_REG_COMM_EN);
        chk(rd === 16'h0001, "comm default");
        $display("test home done");
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        boot(16'h0001, 16'h0000, 15'h0000);
        t_regs;
        t_follow;
        t_stop;
        t_mech;
        t_switch;
        t_home;
        test_done;
    end
    // Cuts a hang short well past the longest expected run.
    initial begin
        #4750000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done;
    end
endmodule // servo_motion_homing_control_tb
`default_nettype wire
